// ---- rtl/rbh_defines.svh ----
// Rear bus hop constants
`ifndef RBH_DEFINES_SVH
`define RBH_DEFINES_SVH

// Register indexes
`define RBH_REG_CTRL 4'h0
`define RBH_REG_TRIGPOS 4'h1
`define RBH_REG_STATUS 4'h2
`define RBH_REG_HOPADDR 4'h3
`define RBH_REG_COUNT 4'h4

// Control register fields
`define RBH_CTRL_BURST_EXT 0
`define RBH_CTRL_DEMOD_EXT 1
`define RBH_CTRL_MSYNC_EXT 2
`define RBH_CTRL_GEN_HOP 3
`define RBH_CTRL_GEN_ARM 4
`define RBH_CTRL_ANA_HOP 5
`define RBH_CTRL_ANA_ARM 6
`define RBH_CTRL_SRC_SEQ 7
`define RBH_CTRL_SETTABLE 8
`define RBH_CTRL_BURST_LO 9
`define RBH_CTRL_W 11
`define RBH_CTRL_RESET 11'h000

// Trigger position register fields
`define RBH_TPOS_BIT_LO 0
`define RBH_TPOS_SLOT_LO 8

// Upper half of a status word
`define RBH_HI_LO 16

// Bit period and core clock period
`define RBH_BIT_PERIOD_NS 3692
`define RBH_CLK_PERIOD_NS 8
`define RBH_BIT_CYCLES (`RBH_BIT_PERIOD_NS / `RBH_CLK_PERIOD_NS)
`define RBH_BITS_PER_SLOT 156
`define RBH_SLOTS_PER_FRAME 8

// Sync reset image: idle pin levels
`define RBH_SYNC_W 20
`define RBH_SYNC_RESET 20'h001C0

`endif

// ---- rtl/rbh_pkg.sv ----
// Types shared by the rear bus hop block
package rbh_pkg;
   typedef logic [10:0] rbh_hop_addr_t;
   typedef logic [1:0] rbh_burst_t;
   typedef logic [7:0] rbh_bit_t;
   typedef logic [2:0] rbh_slot_t;
   typedef logic [10:0] rbh_frame_t;
   typedef logic [31:0] rbh_word_t;
endpackage

// ---- rtl/rbh_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`include "rbh_defines.svh"
module rbh_sync
   import rbh_pkg::*;
#(
   parameter int W = `RBH_SYNC_W,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Pins and their synchronised image
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;

   // First flop feeds only the second
   for (genvar g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            meta[g] <= RST_VAL[g];
            o_sync[g] <= RST_VAL[g];
         end else begin
            meta[g] <= i_async[g];
            o_sync[g] <= meta[g];
         end
      end
   end
endmodule

// ---- rtl/rbh_gsm_counter.sv ----
// Bit, timeslot and frame counters with a one-cycle bit tick
`timescale 1ns/1ns
`include "rbh_defines.svh"
module rbh_gsm_counter
   import rbh_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Halt and clear while high
   input wire logic i_halt,
   // Counter state
   output logic o_bit_tick,
   output rbh_bit_t o_bit,
   output rbh_slot_t o_slot,
   output rbh_frame_t o_frame
);
   logic [8:0] div;
   logic [8:0] next_div;
   logic next_tick;
   rbh_bit_t next_bit;
   rbh_slot_t next_slot;
   rbh_frame_t next_frame;

   // Bit-rate enable divider; halt clears all
   always_comb begin
      next_div = div + 9'h001;
      next_tick = 1'b0;
      next_bit = o_bit;
      next_slot = o_slot;
      next_frame = o_frame;
      if (i_halt) begin
         next_div = 9'h000;
         next_bit = 8'h00;
         next_slot = 3'h0;
         next_frame = 11'h000;
      end else if (div == 9'(`RBH_BIT_CYCLES - 1)) begin
         next_div = 9'h000;
         next_tick = 1'b1;
         if (o_bit == 8'(`RBH_BITS_PER_SLOT - 1)) begin
            next_bit = 8'h00;
            if (o_slot == 3'(`RBH_SLOTS_PER_FRAME - 1)) begin
               next_slot = 3'h0;
               next_frame = o_frame + 11'h001; // Wraps at the field width
            end else begin
               next_slot = o_slot + 3'h1;
            end
         end else begin
            next_bit = o_bit + 8'h01;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div <= 9'h000;
         o_bit_tick <= 1'b0;
         o_bit <= 8'h00;
         o_slot <= 3'h0;
         o_frame <= 11'h000;
      end else begin
         div <= next_div;
         o_bit_tick <= next_tick;
         o_bit <= next_bit;
         o_slot <= next_slot;
         o_frame <= next_frame;
      end
   end
endmodule

// ---- rtl/rbh_rear_bus.sv ----
// Rear system bus control
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "rbh_defines.svh"
// What this block does
// - Burst pins decode 0..3, second pin MSB
// - Burst pins honoured only when source external
// - Demod trigger acts on rising edge
// - Demod trigger needs external source
// - Low counter reset halts and clears counters
// - Halted output low while counters halted
// - Halted output low always in settable mode
// - Hop address unsigned binary, high means one
// - Generator trigger samples address when armed external
// - Analyzer trigger samples address when armed external
// - Sequence trigger samples address when sequenced, armed, reset pending
// - Address selects table entry, or loads sequence
// - Inhibit blocks hops, sequence still advances
// - Inhibit honoured only with sequenced source
// - Demod outputs identical on rear and front
// - External trigger one bit wide at slot/bit
// - Measurement output high while measurement runs
// - Sequence reset applied at next sequence trigger
// - Sequence output pulses on jump or reset
// - Sequence trigger steps tables when sequenced
module rbh_rear_bus
   import rbh_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   output rbh_word_t o_reg_rdata,
   // System bus input pins
   input wire logic i_burst_select_lsb,
   input wire logic i_burst_select_msb,
   input wire logic i_demod_trigger_in,
   input wire logic i_frame_counter_reset_n,
   input wire logic [10:0] i_hop_table_address,
   input wire logic i_generator_hop_trigger,
   input wire logic i_analyzer_hop_trigger,
   input wire logic i_sequence_hop_trigger,
   input wire logic i_sequence_reset_n,
   input wire logic i_internal_hop_inhibit_n,
   // From the demodulator and measurement engine
   input wire logic i_demod_data,
   input wire logic i_demod_clk,
   input wire logic i_demod_valid,
   input wire logic i_meas_in_progress,
   // System bus output pins
   output logic o_counters_halted_n,
   output logic o_ext_trigger_out,
   output logic o_measurement_active_out,
   output logic o_sequence_trigger_out,
   output logic o_demod_data_rear,
   output logic o_demod_clk_rear,
   output logic o_demod_valid_rear,
   output logic o_demod_data_front,
   output logic o_demod_clk_front,
   output logic o_demod_valid_front,
   // To the demodulator and hop controller
   output rbh_burst_t o_burst_number,
   output logic o_demod_trigger,
   output rbh_hop_addr_t o_gen_hop_address,
   output logic o_gen_hop_strobe,
   output rbh_hop_addr_t o_ana_hop_address,
   output logic o_ana_hop_strobe
);
   // Synchronised pins
   logic [`RBH_SYNC_W-1:0] pins;
   logic s_bsel_lsb;
   logic s_bsel_msb;
   logic s_demod_trig;
   logic s_frame_rst_n;
   logic s_seq_rst_n;
   logic s_inhibit_n;
   logic s_gen_trig;
   logic s_ana_trig;
   logic s_seq_trig;
   rbh_hop_addr_t s_addr;

   // Edge detection history
   logic prev_demod;
   logic prev_gen;
   logic prev_ana;
   logic prev_seq;
   logic demod_rise;
   logic gen_rise;
   logic ana_rise;
   logic seq_rise;

   // Registers
   logic [`RBH_CTRL_W-1:0] ctrl;
   logic [`RBH_CTRL_W-1:0] next_ctrl;
   rbh_bit_t trig_bit;
   rbh_bit_t next_trig_bit;
   rbh_slot_t trig_slot;
   rbh_slot_t next_trig_slot;
   rbh_word_t next_rdata;

   // Control fields
   logic burst_ext;
   logic trig_ext;
   logic gen_armed;
   logic ana_armed;
   logic src_seq;
   logic settable;

   // Sequencer state
   rbh_hop_addr_t seq_addr;
   rbh_hop_addr_t next_seq_addr;
   logic rst_pending;
   logic next_rst_pending;

   // Counters
   logic halted;
   logic bit_tick;
   rbh_bit_t cnt_bit;
   rbh_slot_t cnt_slot;
   rbh_frame_t cnt_frame;

   // Next output values
   rbh_burst_t next_burst;
   logic next_demod_trigger;
   rbh_hop_addr_t next_gen_addr;
   logic next_gen_strobe;
   rbh_hop_addr_t next_ana_addr;
   logic next_ana_strobe;
   logic next_seq_out;
   logic next_halted_n;
   logic next_ext_trig;

   // Two flops on every pin
   rbh_sync #(
      .W(`RBH_SYNC_W),
      .RST_VAL(`RBH_SYNC_RESET)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_hop_table_address, i_internal_hop_inhibit_n, i_sequence_reset_n,
                i_frame_counter_reset_n, i_sequence_hop_trigger, i_analyzer_hop_trigger,
                i_generator_hop_trigger, i_demod_trigger_in, i_burst_select_msb,
                i_burst_select_lsb}),
      .o_sync(pins)
   );

   assign s_bsel_lsb = pins[0];
   assign s_bsel_msb = pins[1];
   assign s_demod_trig = pins[2];
   assign s_gen_trig = pins[3];
   assign s_ana_trig = pins[4];
   assign s_seq_trig = pins[5];
   assign s_frame_rst_n = pins[6];
   assign s_seq_rst_n = pins[7];
   assign s_inhibit_n = pins[8];
   assign s_addr = pins[19:9];

   // Trigger rising edges
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_demod <= 1'b0;
         prev_gen <= 1'b0;
         prev_ana <= 1'b0;
         prev_seq <= 1'b0;
      end else begin
         prev_demod <= s_demod_trig;
         prev_gen <= s_gen_trig;
         prev_ana <= s_ana_trig;
         prev_seq <= s_seq_trig;
      end
   end

   assign demod_rise = s_demod_trig & ~prev_demod;
   assign gen_rise = s_gen_trig & ~prev_gen;
   assign ana_rise = s_ana_trig & ~prev_ana;
   assign seq_rise = s_seq_trig & ~prev_seq;

   // Control field decode
   assign burst_ext = ctrl[`RBH_CTRL_BURST_EXT];
   assign trig_ext = ctrl[`RBH_CTRL_DEMOD_EXT] | ctrl[`RBH_CTRL_MSYNC_EXT];
   assign gen_armed = ctrl[`RBH_CTRL_GEN_HOP] & ctrl[`RBH_CTRL_GEN_ARM];
   assign ana_armed = ctrl[`RBH_CTRL_ANA_HOP] & ctrl[`RBH_CTRL_ANA_ARM];
   assign src_seq = ctrl[`RBH_CTRL_SRC_SEQ];
   assign settable = ctrl[`RBH_CTRL_SETTABLE];

   // Register writes; read data for the next cycle
   always_comb begin
      next_ctrl = ctrl;
      next_trig_bit = trig_bit;
      next_trig_slot = trig_slot;
      next_rdata = 32'h00000000;
      if (i_reg_write) begin
         case (i_reg_addr)
            `RBH_REG_CTRL: begin
               next_ctrl = i_reg_wdata[`RBH_CTRL_W-1:0];
            end
            `RBH_REG_TRIGPOS: begin
               next_trig_bit = i_reg_wdata[`RBH_TPOS_BIT_LO +: 8];
               next_trig_slot = i_reg_wdata[`RBH_TPOS_SLOT_LO +: 3];
            end
            default: begin
               next_ctrl = ctrl; // Status words and holes ignore writes
            end
         endcase
      end
      if (i_reg_read) begin
         case (i_reg_addr)
            `RBH_REG_CTRL: begin
               next_rdata[`RBH_CTRL_W-1:0] = ctrl;
            end
            `RBH_REG_TRIGPOS: begin
               next_rdata[`RBH_TPOS_BIT_LO +: 8] = trig_bit;
               next_rdata[`RBH_TPOS_SLOT_LO +: 3] = trig_slot;
            end
            `RBH_REG_STATUS: begin
               next_rdata[1:0] = o_burst_number;
               next_rdata[2] = halted;
               next_rdata[3] = rst_pending;
               next_rdata[`RBH_HI_LO +: 11] = seq_addr;
            end
            `RBH_REG_HOPADDR: begin
               next_rdata[10:0] = o_gen_hop_address;
               next_rdata[`RBH_HI_LO +: 11] = o_ana_hop_address;
            end
            `RBH_REG_COUNT: begin
               next_rdata[7:0] = cnt_bit;
               next_rdata[10:8] = cnt_slot;
               next_rdata[`RBH_HI_LO +: 11] = cnt_frame;
            end
            default: begin
               next_rdata = 32'h00000000; // Unmapped reads return zero
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl <= `RBH_CTRL_RESET;
         trig_bit <= 8'h00;
         trig_slot <= 3'h0;
         o_reg_rdata <= 32'h00000000;
      end else begin
         ctrl <= next_ctrl;
         trig_bit <= next_trig_bit;
         trig_slot <= next_trig_slot;
         o_reg_rdata <= next_rdata;
      end
   end

   // Counters, held clear while the reset pin is low
   assign halted = ~s_frame_rst_n;

   rbh_gsm_counter u_counter (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_halt(halted),
      .o_bit_tick(bit_tick),
      .o_bit(cnt_bit),
      .o_slot(cnt_slot),
      .o_frame(cnt_frame)
   );

   // Hop capture and the internal sequence
   always_comb begin
      next_seq_addr = seq_addr;
      next_rst_pending = rst_pending;
      next_gen_addr = o_gen_hop_address;
      next_gen_strobe = 1'b0;
      next_ana_addr = o_ana_hop_address;
      next_ana_strobe = 1'b0;
      next_seq_out = 1'b0;
      // A low reset pin only arms; the next trigger applies it
      if (src_seq && !s_seq_rst_n) begin
         next_rst_pending = 1'b1;
      end
      if (!src_seq) begin
         if (gen_rise && gen_armed) begin
            next_gen_addr = s_addr;
            next_gen_strobe = 1'b1;
         end
         if (ana_rise && ana_armed) begin
            next_ana_addr = s_addr;
            next_ana_strobe = 1'b1;
         end
      end else if (seq_rise && (gen_armed || ana_armed)) begin
         if (rst_pending || !s_seq_rst_n) begin
            next_seq_addr = s_addr;
            next_rst_pending = 1'b0;
            next_seq_out = 1'b1;
         end else begin
            next_seq_addr = seq_addr + 11'h001;
            next_seq_out = (seq_addr == 11'h7FF); // Wrap is a jump
         end
         // Inhibit stops the hop, never the sequence
         if (s_inhibit_n) begin
            next_gen_addr = gen_armed ? next_seq_addr : o_gen_hop_address;
            next_gen_strobe = gen_armed;
            next_ana_addr = ana_armed ? next_seq_addr : o_ana_hop_address;
            next_ana_strobe = ana_armed;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seq_addr <= 11'h000;
         rst_pending <= 1'b0;
         o_gen_hop_address <= 11'h000;
         o_gen_hop_strobe <= 1'b0;
         o_ana_hop_address <= 11'h000;
         o_ana_hop_strobe <= 1'b0;
         o_sequence_trigger_out <= 1'b0;
      end else begin
         seq_addr <= next_seq_addr;
         rst_pending <= next_rst_pending;
         o_gen_hop_address <= next_gen_addr;
         o_gen_hop_strobe <= next_gen_strobe;
         o_ana_hop_address <= next_ana_addr;
         o_ana_hop_strobe <= next_ana_strobe;
         o_sequence_trigger_out <= next_seq_out;
      end
   end

   // Burst, demod trigger, halt flag, trigger out
   always_comb begin
      next_burst = ctrl[`RBH_CTRL_BURST_LO +: 2];
      if (burst_ext) begin
         next_burst = {s_bsel_msb, s_bsel_lsb};
      end
      next_demod_trigger = demod_rise & trig_ext;
      next_halted_n = ~(halted | settable);
      // Counter holds a whole bit, so the match lasts one bit
      next_ext_trig = ~halted & (cnt_slot == trig_slot) & (cnt_bit == trig_bit);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_burst_number <= 2'h0;
         o_demod_trigger <= 1'b0;
         o_counters_halted_n <= 1'b0;
         o_ext_trigger_out <= 1'b0;
      end else begin
         o_burst_number <= next_burst;
         o_demod_trigger <= next_demod_trigger;
         o_counters_halted_n <= next_halted_n;
         o_ext_trigger_out <= next_ext_trig;
      end
   end

   // Rear and front demod copies from one input
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_demod_data_rear <= 1'b0;
         o_demod_clk_rear <= 1'b0;
         o_demod_valid_rear <= 1'b0;
         o_demod_data_front <= 1'b0;
         o_demod_clk_front <= 1'b0;
         o_demod_valid_front <= 1'b0;
         o_measurement_active_out <= 1'b0;
      end else begin
         o_demod_data_rear <= i_demod_data;
         o_demod_clk_rear <= i_demod_clk;
         o_demod_valid_rear <= i_demod_valid;
         o_demod_data_front <= i_demod_data;
         o_demod_clk_front <= i_demod_clk;
         o_demod_valid_front <= i_demod_valid;
         o_measurement_active_out <= i_meas_in_progress;
      end
   end
endmodule

// ---- sim/rbh_rear_bus_monitor.sv ----
// Port-level assertions for the rear bus hop block
`timescale 1ns/1ns
`include "rbh_defines.svh"
module rbh_rear_bus_monitor
   import rbh_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Watched inputs
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_burst_select_lsb,
   input wire logic i_burst_select_msb,
   input wire logic i_demod_trigger_in,
   input wire logic i_frame_counter_reset_n,
   input wire logic [10:0] i_hop_table_address,
   input wire logic i_generator_hop_trigger,
   input wire logic i_internal_hop_inhibit_n,
   input wire logic i_meas_in_progress,
   // Watched outputs
   input wire logic o_counters_halted_n,
   input wire logic o_ext_trigger_out,
   input wire logic o_measurement_active_out,
   input wire logic o_sequence_trigger_out,
   input wire logic o_demod_data_rear,
   input wire logic o_demod_clk_rear,
   input wire logic o_demod_valid_rear,
   input wire logic o_demod_data_front,
   input wire logic o_demod_clk_front,
   input wire logic o_demod_valid_front,
   input wire rbh_burst_t o_burst_number,
   input wire logic o_demod_trigger,
   input wire rbh_hop_addr_t o_gen_hop_address,
   input wire logic o_gen_hop_strobe,
   input wire logic o_ana_hop_strobe
);
   localparam int BITC = `RBH_BIT_CYCLES;
   logic [10:0] ctrl;
   logic [10:0] next_ctrl;
   logic [11:0] hi_cnt;
   logic [11:0] next_hi_cnt;
   logic whole;
   logic next_whole;
   // Control mirror; width judged only for uncut pulses
   always_comb begin
      next_ctrl = (i_reg_write && i_reg_addr == `RBH_REG_CTRL) ? i_reg_wdata[10:0] : ctrl;
      next_hi_cnt = o_ext_trigger_out ? hi_cnt + 12'h001 : 12'h000;
      next_whole = !o_ext_trigger_out || (whole && i_frame_counter_reset_n &&
         !(i_reg_write && i_reg_addr == `RBH_REG_TRIGPOS));
   end
   // Helper registers
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl <= `RBH_CTRL_RESET;
         hi_cnt <= 12'h000;
         whole <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         hi_cnt <= next_hi_cnt;
         whole <= next_whole;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   a_burst_decode: assert property (($stable({i_burst_select_msb, i_burst_select_lsb}) && $stable(ctrl)) [*4]
      |-> o_burst_number == (ctrl[0] ? {i_burst_select_msb, i_burst_select_lsb} : ctrl[10:9]))
      else $error("burst number wrong");
   a_demod_follow: assert property ($rose(i_demod_trigger_in) && (ctrl[1] || ctrl[2]) |-> ##[2:5] o_demod_trigger)
      else $error("demod trigger missed");
   a_demod_source: assert property (o_demod_trigger |-> ctrl[1] || ctrl[2])
      else $error("demod without source");
   a_halt_pin: assert property (!i_frame_counter_reset_n [*4] |=> !o_counters_halted_n)
      else $error("halt not shown");
   a_halt_settable: assert property (ctrl[8] [*3] |-> !o_counters_halted_n)
      else $error("settable not shown");
   a_halt_release: assert property ((i_frame_counter_reset_n && !ctrl[8]) [*4] |=> o_counters_halted_n)
      else $error("halt not released");
   a_gen_follow: assert property ($rose(i_generator_hop_trigger) && ctrl[3] && ctrl[4] && !ctrl[7]
      |-> ##[2:5] o_gen_hop_strobe) else $error("gen hop missed");
   a_gen_address: assert property (o_gen_hop_strobe && !ctrl[7]
      |-> o_gen_hop_address == $past(i_hop_table_address, 3)) else $error("gen address wrong");
   a_strobe_armed: assert property (o_gen_hop_strobe |-> ctrl[3] && ctrl[4])
      else $error("hop while not armed");
   a_inhibit_quiet: assert property ((ctrl[7] && !i_internal_hop_inhibit_n) [*5]
      |-> !o_gen_hop_strobe && !o_ana_hop_strobe) else $error("hop while inhibited");
   a_ext_width: assert property ($fell(o_ext_trigger_out) && whole |-> hi_cnt == BITC)
      else $error("trigger width wrong");
   a_demod_mirror: assert property ({o_demod_data_rear, o_demod_clk_rear, o_demod_valid_rear} ==
      {o_demod_data_front, o_demod_clk_front, o_demod_valid_front}) else $error("rear and front differ");
   a_meas_follow: assert property (o_measurement_active_out == $past(i_meas_in_progress))
      else $error("measurement output lags");
   a_seq_pulse: assert property (o_sequence_trigger_out |=> !o_sequence_trigger_out)
      else $error("sequence pulse too long");
endmodule

// ---- sim/rbh_far_end.sv ----
// Far-end hop controller model
`timescale 1ns/1ns
module rbh_far_end
   import rbh_pkg::*;
(
   // Rear hop pins only
   output rbh_hop_addr_t o_hop_table_address,
   output logic [2:0] o_hop_triggers
);
   // Triggers idle low
   initial begin
      o_hop_table_address = 11'h2AA;
      o_hop_triggers = 3'h0;
   end
   // One hop: address set up before the rise, held after it
   task automatic hop(input int k, input rbh_hop_addr_t a);
      #37 o_hop_table_address = a;
      #80 o_hop_triggers[k] = 1'b1;
      #160 o_hop_triggers[k] = 1'b0;
      #160 o_hop_table_address = ~a; // Released lines invert
      #80;
   endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench, rear bus hop block
`timescale 1ns/1ns
`include "rbh_defines.svh"
module testbench
   import rbh_pkg::*;
;
   localparam int BITC = `RBH_BIT_CYCLES;
   logic clk = 1'b0;
   logic rst_b, we, re, lsb, msb, dtrig, frst_n, srst_n, inh_n, dd, dc, dv, meas;
   logic [3:0] addr;
   rbh_word_t wd, rdata;
   rbh_hop_addr_t hop_addr, gen_addr, ana_addr;
   logic [2:0] trig, rear, front;
   logic halted_n, ext_trig, meas_out, seq_trig, dem_o, gen_stb, ana_stb;
   rbh_burst_t burst;
   int n_gen = 0, n_ana = 0, n_seq = 0, n_dem = 0, failures = 0, checked = 0;
   always #4 clk = ~clk;
   // Pulse counters so no one-cycle strobe is missed
   always @(posedge clk) begin
      n_gen <= n_gen + (gen_stb === 1'b1);
      n_ana <= n_ana + (ana_stb === 1'b1);
      n_seq <= n_seq + (seq_trig === 1'b1);
      n_dem <= n_dem + (dem_o === 1'b1);
   end
   rbh_far_end i_far (.o_hop_table_address(hop_addr), .o_hop_triggers(trig));
   rbh_rear_bus i_rbh_rear_bus (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wd),
      .i_reg_write(we), .i_reg_read(re), .o_reg_rdata(rdata), .i_burst_select_lsb(lsb),
      .i_burst_select_msb(msb), .i_demod_trigger_in(dtrig), .i_frame_counter_reset_n(frst_n),
      .i_hop_table_address(hop_addr), .i_generator_hop_trigger(trig[0]), .i_analyzer_hop_trigger(trig[1]),
      .i_sequence_hop_trigger(trig[2]), .i_sequence_reset_n(srst_n), .i_internal_hop_inhibit_n(inh_n),
      .i_demod_data(dd), .i_demod_clk(dc), .i_demod_valid(dv), .i_meas_in_progress(meas),
      .o_counters_halted_n(halted_n), .o_ext_trigger_out(ext_trig), .o_measurement_active_out(meas_out),
      .o_sequence_trigger_out(seq_trig), .o_demod_data_rear(rear[2]), .o_demod_clk_rear(rear[1]),
      .o_demod_valid_rear(rear[0]), .o_demod_data_front(front[2]), .o_demod_clk_front(front[1]),
      .o_demod_valid_front(front[0]), .o_burst_number(burst), .o_demod_trigger(dem_o),
      .o_gen_hop_address(gen_addr), .o_gen_hop_strobe(gen_stb), .o_ana_hop_address(ana_addr),
      .o_ana_hop_strobe(ana_stb));
   // Bench helpers
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task close_out;
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [3:0] a, input rbh_word_t d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output rbh_word_t d);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1 d = rdata;
   endtask
   task t_regs;
      rbh_word_t d;
      rd(`RBH_REG_CTRL, d);
      chk(d, `RBH_CTRL_RESET);
      wr(`RBH_REG_TRIGPOS, 32'h0000_0002);
      rd(`RBH_REG_TRIGPOS, d);
      chk(d, 32'h0000_0002);
      rd(4'h9, d);
      chk(d, 32'h0000_0000);
   endtask
   task t_halt;
      rbh_word_t d;
      int n;
      @(posedge clk) frst_n <= 1'b0;
      cyc(600);
      chk(halted_n, 1'b0);
      rd(`RBH_REG_COUNT, d);
      chk(d, 32'h0000_0000);
      @(posedge clk) frst_n <= 1'b1;
      n = 0;
      while (ext_trig !== 1'b1 && n < 1500) begin
         cyc(1);
         n++;
      end
      if (n == 1500) failures++;
      if (n == 1500) close_out;
      chk(halted_n, 1'b1);
      chk(n >= 2 * BITC && n <= 2 * BITC + 8, 1'b1);
      n = 0;
      while (ext_trig === 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      chk(n, BITC);
      wr(`RBH_REG_CTRL, 32'h0000_0100);
      cyc(5);
      chk(halted_n, 1'b0);
      wr(`RBH_REG_CTRL, 32'h0000_0000);
      cyc(5);
      chk(halted_n, 1'b1);
   endtask
   task t_ext;
      rbh_word_t d;
      int g, a;
      wr(`RBH_REG_CTRL, 32'h0000_0078);
      g = n_gen;
      a = n_ana;
      i_far.hop(0, 11'h5A5);
      cyc(2);
      chk(n_gen - g, 1);
      chk(gen_addr, 11'h5A5);
      i_far.hop(1, 11'h7FF);
      cyc(2);
      chk(n_ana - a, 1);
      chk(ana_addr, 11'h7FF);
      rd(`RBH_REG_HOPADDR, d);
      chk(d, 32'h07FF_05A5);
      // Hop on, nothing armed: all refused
      wr(`RBH_REG_CTRL, 32'h0000_0028);
      i_far.hop(0, 11'h001);
      i_far.hop(1, 11'h002);
      i_far.hop(2, 11'h003);
      cyc(2);
      chk(n_gen - g + n_ana - a, 2);
   endtask
   task t_seq;
      rbh_word_t d;
      int g, s;
      wr(`RBH_REG_CTRL, 32'h0000_0098);
      @(posedge clk) srst_n <= 1'b0;
      cyc(8);
      @(posedge clk) srst_n <= 1'b1;
      cyc(4);
      rd(`RBH_REG_STATUS, d);
      chk(d[3], 1'b1);
      g = n_gen;
      s = n_seq;
      i_far.hop(2, 11'h7FE);
      cyc(2);
      rd(`RBH_REG_STATUS, d);
      chk(d[26:16], 11'h7FE);
      chk(n_seq - s, 1);
      chk(gen_addr, 11'h7FE);
      i_far.hop(2, 11'h123);
      cyc(2);
      chk(gen_addr, 11'h7FF);
      chk(n_seq - s, 1);
      i_far.hop(2, 11'h123);
      cyc(2);
      chk(gen_addr, 11'h000);
      chk(n_seq - s, 2);
      @(posedge clk) inh_n <= 1'b0;
      cyc(4);
      i_far.hop(2, 11'h456);
      cyc(2);
      chk(n_gen - g, 3);
      rd(`RBH_REG_STATUS, d);
      chk(d[26:16], 11'h001);
      // External source ignores inhibit
      wr(`RBH_REG_CTRL, 32'h0000_0018);
      i_far.hop(0, 11'h321);
      cyc(2);
      chk(n_gen - g, 4);
      @(posedge clk) inh_n <= 1'b1;
   endtask
   task t_burst;
      wr(`RBH_REG_CTRL, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         msb <= i[1];
         lsb <= i[0];
         cyc(6);
         chk(burst, i[1:0]);
      end
      wr(`RBH_REG_CTRL, 32'h0000_0400);
      cyc(4);
      chk(burst, 2'h2);
   endtask
   task t_demod;
      int m;
      for (int k = 0; k < 3; k++) begin
         wr(`RBH_REG_CTRL, k << 1);
         m = n_dem;
         @(posedge clk) dtrig <= 1'b1;
         cyc(10);
         chk(n_dem - m, k != 0);
         @(posedge clk) dtrig <= 1'b0;
         cyc(4);
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         {dd, dc, dv} <= k ? 3'h2 : 3'h5;
         meas <= !k;
         cyc(1);
         chk({rear, front}, k ? 6'h12 : 6'h2D);
         chk(meas_out, !k);
      end
   endtask
   task t_reset;
      @(posedge clk) rst_b <= 1'b0;
      cyc(3);
      chk(halted_n, 1'b0);
      @(posedge clk) rst_b <= 1'b1;
      cyc(5);
      chk(halted_n, 1'b1);
   endtask
   // Main sequence; inhibit and sequence reset idle high
   initial begin
      {rst_b, we, re, lsb, msb, dtrig, dd, dc, dv, meas} = 10'h000;
      {frst_n, srst_n, inh_n} = 3'h7;
      addr = 4'h0;
      wd = 32'h0000_0000;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_halt;
      t_ext;
      t_seq;
      t_burst;
      t_demod;
      t_reset;
      close_out;
   end
endmodule
bind rbh_rear_bus rbh_rear_bus_monitor i_mon (.*);
